// ===== zpg_pkg.sv
// zpg_pkg: constants and types shared by the zone plate generator files
package zpg_pkg;
  // raster of the active format, one sample per enabled clock
  localparam int H_ACTIVE = 1920;
  localparam int H_TOTAL = 2200;
  localparam int V_ACTIVE = 1080;
  localparam int V_TOTAL = 1125;
  localparam int H_SYNC_LEN = 44;
  localparam int V_SYNC_LEN = 5;
  // time steps once per frame; per-second values scale by 1/rate
  localparam int FRAME_RATE_HZ = 30;
  localparam logic [31:0] FRAME_SCALE = 32'(65536 / FRAME_RATE_HZ);
  localparam int FRAME_SHIFT = 16;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_AMPL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_COEF = 8'h10;
  localparam int NUM_COEF = 10;
  // coefficient slots, in word order from OFS_COEF
  localparam int C_PHASE = 0;
  localparam int C_HFREQ = 1;
  localparam int C_HSWEEP = 2;
  localparam int C_HBYV = 3;
  localparam int C_VFREQ = 4;
  localparam int C_VSWEEP = 5;
  localparam int C_HBYT = 6;
  localparam int C_VBYT = 7;
  localparam int C_TFREQ = 8;
  localparam int C_TSWEEP = 9;

  // control word fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_DEFAULTS_BIT = 1;
  localparam int CTRL_SPACE_LSB = 2;
  localparam logic [1:0] SPACE_YCC = 2'h0;
  localparam logic [1:0] SPACE_RGB = 2'h1;
  localparam logic [1:0] SPACE_XYZ = 2'h2;
  localparam logic CTRL_RUN_RESET = 1'b1;

  // amplitude in half-millivolt steps
  localparam logic [10:0] AMPL_MAX = 11'h63C;
  localparam logic [10:0] AMPL_DEFAULT = 11'h578;
  localparam logic [2:0] EN_DEFAULT_YCC = 3'h1;
  localparam logic [2:0] EN_DEFAULT_RGB = 3'h7;

  // output codes and swing scaling
  localparam logic [11:0] BLACK_CODE = 12'h100;
  localparam logic [11:0] LUMA_MID = 12'h7D8;
  localparam logic [11:0] CHROMA_MID = 12'h800;
  localparam logic [27:0] SWING_GAIN = 28'h0000005;
  localparam int SWING_SHIFT = 13;
  localparam logic [11:0] SINE_PEAK = 12'h7FF;
  localparam int PIPE_DEPTH = 3;

  typedef enum logic [1:0] {
    ZPG_IDLE = 2'b01,
    ZPG_ANSWER = 2'b10
  } zpg_bus_t;
endpackage

// ===== zpg_sine.sv
// zpg_sine: registered parabolic sine of a phase fraction
`timescale 1ns/1ps
module zpg_sine import zpg_pkg::*; (
  input wire logic ref_clk, // sample clock
  input wire logic reset_n, // synchronous reset
  input wire logic [11:0] phase, // top bits of the cycle fraction
  output logic signed [12:0] sine // signed sine, peak SINE_PEAK
);
  logic [10:0] u;
  logic [21:0] prod;
  logic [11:0] mag;
  logic signed [12:0] sine_nxt;

  // each half cycle is a parabola; cheap, but not a pure sine
  always_comb begin
    u = phase[10:0];
    prod = 22'(u) * 22'(12'h800 - {1'b0, u});
    mag = (prod[21:9] > 13'(SINE_PEAK)) ? SINE_PEAK : prod[20:9];
    sine_nxt = phase[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sine <= 13'sh0000;
    end else begin
      sine <= sine_nxt;
    end
  end
endmodule // zpg_sine

// ===== zpg_scale.sv
// zpg_scale: scales the sine by the programmed amplitude
`timescale 1ns/1ps
module zpg_scale import zpg_pkg::*; (
  input wire logic ref_clk, // sample clock
  input wire logic reset_n, // synchronous reset
  input wire logic signed [12:0] sine, // signed sine sample
  input wire logic [10:0] ampl, // amplitude, half-mV steps
  output logic signed [12:0] swing // signed code swing about centre
);
  logic signed [27:0] prod;
  logic signed [27:0] shifted;
  logic signed [12:0] swing_nxt;

  // codes per half-mV chosen so 700 mV spans black to white
  always_comb begin
    prod = 28'(sine) * $signed({17'h00000, ampl}) * $signed(SWING_GAIN);
    shifted = prod >>> SWING_SHIFT;
    swing_nxt = shifted[12:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      swing <= 13'sh0000;
    end else begin
      swing <= swing_nxt;
    end
  end
endmodule // zpg_scale

// ===== zpg_generator.sv
// zpg_generator: zone plate pattern generator with Avalon-MM registers
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module zpg_generator import zpg_pkg::*; (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic [7:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // write byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // low for the answer cycle
  output logic [11:0] vid_comp0, // Y, G or X sample
  output logic [11:0] vid_comp1, // Cb, B or Y sample
  output logic [11:0] vid_comp2, // Cr, R or Z sample
  output logic vid_active, // sample lies in the active picture
  output logic vid_hsync, // line sync, high during pulse
  output logic vid_vsync // frame sync, high during pulse
);
  // merge write data into a word under the byte lanes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // per-second coefficient to per-frame step
  function automatic logic [31:0] per_frame(input logic [31:0] c);
    logic signed [63:0] p;
    p = 64'($signed(c)) * $signed({32'h00000000, FRAME_SCALE});
    return p[FRAME_SHIFT +: 32];
  endfunction

  // pattern enables that a colour space starts with
  function automatic logic [2:0] space_default(input logic [1:0] sp);
    return (sp == SPACE_YCC) ? EN_DEFAULT_YCC : EN_DEFAULT_RGB;
  endfunction

  // one output channel: centred swing when enabled, idle code otherwise
  function automatic logic [11:0] chan(input logic en,
                                       input logic signed [12:0] sw,
                                       input logic [11:0] centre,
                                       input logic [11:0] idle);
    logic [12:0] sum;
    sum = 13'(centre) + 13'(sw);
    return en ? sum[11:0] : idle;
  endfunction

  // ---------------- register and bus state ----------------
  zpg_bus_t bus_r, bus_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic run_r, run_nxt;
  logic [1:0] space_r, space_nxt;
  logic [2:0] enable_r, enable_nxt;
  logic [10:0] ampl_r, ampl_nxt;
  logic [31:0] coef_r [NUM_COEF];
  logic [31:0] coef_nxt [NUM_COEF];
  logic [15:0] frames_r, frames_nxt;
  logic wr_hit;
  logic [31:0] wmerge;
  logic [3:0] cidx;

  // bus answers one cycle after a request; write acts at the answer edge
  always_comb begin
    bus_nxt = bus_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    run_nxt = run_r;
    space_nxt = space_r;
    enable_nxt = enable_r;
    ampl_nxt = ampl_r;
    coef_nxt = coef_r;
    wmerge = 32'h00000000;
    cidx = 4'(({2'b00, avs_address} - {2'b00, OFS_COEF}) >> 2);
    wr_hit = 1'b0;
    case (bus_r)
      ZPG_IDLE: begin
        if (avs_read || avs_write) begin
          bus_nxt = ZPG_ANSWER;
          wait_nxt = 1'b0;
          // read data built now so it stands on the answer cycle
          if (avs_address == OFS_CTRL) begin
            rdata_nxt = {28'h0000000, space_r, 1'b0, run_r};
          end else if (avs_address == OFS_ENABLE) begin
            rdata_nxt = {29'h00000000, enable_r};
          end else if (avs_address == OFS_AMPL) begin
            rdata_nxt = {21'h000000, ampl_r};
          end else if (avs_address == OFS_STATUS) begin
            rdata_nxt = {16'h0000, frames_r};
          end else if (avs_address >= OFS_COEF &&
                       avs_address < OFS_COEF + 8'(4 * NUM_COEF) &&
                       avs_address[1:0] == 2'b00) begin
            rdata_nxt = coef_r[cidx];
          end else begin
            rdata_nxt = 32'h00000000; // unmapped reads as zero
          end
        end
      end
      ZPG_ANSWER: begin
        bus_nxt = ZPG_IDLE;
        wr_hit = avs_write;
      end
      default: begin
        bus_nxt = ZPG_IDLE;
      end
    endcase
    if (wr_hit) begin
      if (avs_address == OFS_CTRL) begin
        wmerge = merge_be({28'h0000000, space_r, 1'b0, run_r},
                          avs_writedata, avs_byteenable);
        run_nxt = wmerge[CTRL_RUN_BIT];
        space_nxt = wmerge[CTRL_SPACE_LSB +: 2];
        if (wmerge[CTRL_DEFAULTS_BIT]) begin
          ampl_nxt = AMPL_DEFAULT;
          enable_nxt = space_default(wmerge[CTRL_SPACE_LSB +: 2]);
        end
      end else if (avs_address == OFS_ENABLE) begin
        wmerge = merge_be({29'h00000000, enable_r},
                          avs_writedata, avs_byteenable);
        enable_nxt = wmerge[2:0];
      end else if (avs_address == OFS_AMPL) begin
        wmerge = merge_be({21'h000000, ampl_r},
                          avs_writedata, avs_byteenable);
        // over-range settings stop at the top step
        ampl_nxt = (wmerge[31:11] != 21'h000000 ||
                    wmerge[10:0] > AMPL_MAX) ? AMPL_MAX : wmerge[10:0];
      end else if (avs_address >= OFS_COEF &&
                   avs_address < OFS_COEF + 8'(4 * NUM_COEF) &&
                   avs_address[1:0] == 2'b00) begin
        // signed coefficients, so negative settings are legal
        coef_nxt[cidx] = merge_be(coef_r[cidx], avs_writedata,
                                  avs_byteenable);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      bus_r <= ZPG_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      run_r <= CTRL_RUN_RESET;
      space_r <= SPACE_YCC;
      enable_r <= EN_DEFAULT_YCC;
      ampl_r <= AMPL_DEFAULT;
      for (int i = 0; i < NUM_COEF; i++) begin
        coef_r[i] <= 32'h00000000;
      end
    end else begin
      bus_r <= bus_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      run_r <= run_nxt;
      space_r <= space_nxt;
      enable_r <= enable_nxt;
      ampl_r <= ampl_nxt;
      coef_r <= coef_nxt;
    end
  end

  // ---------------- raster and phase accumulators ----------------
  logic [11:0] hcnt_r, hcnt_nxt;
  logic [10:0] vcnt_r, vcnt_nxt;
  logic [31:0] h_ph_r, h_ph_nxt; // phase along the line
  logic [31:0] h_rate_r, h_rate_nxt; // phase step per sample
  logic [31:0] v_ph_r, v_ph_nxt; // phase down the frame
  logic [31:0] v_rate_r, v_rate_nxt; // phase step per line
  logic [31:0] hxy_r, hxy_nxt; // h-by-v frequency this line
  logic [31:0] hxt_r, hxt_nxt; // h-by-t frequency this frame
  logic [31:0] vyt_r, vyt_nxt; // v-by-t frequency this frame
  logic [31:0] t_lin_r, t_lin_nxt; // linear time phase
  logic [31:0] t_sq_r, t_sq_nxt; // half-square time phase
  logic [31:0] t_rate_r, t_rate_nxt; // half-square time step
  logic [31:0] phase_sum;
  logic [31:0] line_rate;
  logic [31:0] tsw_step;
  logic line_end, frame_end;
  logic active_now;

  // all phases wrap modulo one cycle, so frequencies fold at fs/2
  always_comb begin
    hcnt_nxt = hcnt_r;
    vcnt_nxt = vcnt_r;
    h_ph_nxt = h_ph_r;
    h_rate_nxt = h_rate_r;
    v_ph_nxt = v_ph_r;
    v_rate_nxt = v_rate_r;
    hxy_nxt = hxy_r;
    hxt_nxt = hxt_r;
    vyt_nxt = vyt_r;
    t_lin_nxt = t_lin_r;
    t_sq_nxt = t_sq_r;
    t_rate_nxt = t_rate_r;
    frames_nxt = frames_r;
    tsw_step = per_frame(per_frame(coef_r[C_TSWEEP]));
    line_end = (hcnt_r == 12'(H_TOTAL - 1));
    frame_end = line_end && (vcnt_r == 11'(V_TOTAL - 1));
    active_now = (hcnt_r < 12'(H_ACTIVE)) && (vcnt_r < 11'(V_ACTIVE));
    // horizontal frequency of the next line, with half sweep step
    line_rate = coef_r[C_HFREQ] + hxt_r + hxy_r +
                {coef_r[C_HSWEEP][31], coef_r[C_HSWEEP][31:1]};
    if (run_r) begin
      hcnt_nxt = line_end ? 12'h000 : hcnt_r + 12'h001;
      if (active_now) begin
        h_ph_nxt = h_ph_r + h_rate_r;
        h_rate_nxt = h_rate_r + coef_r[C_HSWEEP];
      end
      if (line_end) begin
        vcnt_nxt = frame_end ? 11'h000 : vcnt_r + 11'h001;
        h_ph_nxt = 32'h00000000;
        if (vcnt_r < 11'(V_ACTIVE)) begin
          v_ph_nxt = v_ph_r + v_rate_r;
          v_rate_nxt = v_rate_r + coef_r[C_VSWEEP];
          hxy_nxt = hxy_r + coef_r[C_HBYV];
        end
      end
      // next line's horizontal start uses updated h-by-v term
      if (line_end) begin
        h_rate_nxt = line_rate + (vcnt_r < 11'(V_ACTIVE) ?
                                  coef_r[C_HBYV] : 32'h00000000);
      end
      if (frame_end) begin
        frames_nxt = frames_r + 16'h0001;
        // time moves one frame; per-second steps scaled to per-frame units
        hxt_nxt = hxt_r + per_frame(coef_r[C_HBYT]);
        vyt_nxt = vyt_r + per_frame(coef_r[C_VBYT]);
        t_lin_nxt = t_lin_r + per_frame(coef_r[C_TFREQ]);
        t_sq_nxt = t_sq_r + t_rate_r;
        t_rate_nxt = t_rate_r + tsw_step;
        hxy_nxt = 32'h00000000;
        v_ph_nxt = 32'h00000000;
        v_rate_nxt = coef_r[C_VFREQ] + vyt_nxt +
                     {coef_r[C_VSWEEP][31], coef_r[C_VSWEEP][31:1]};
        h_rate_nxt = coef_r[C_HFREQ] + hxt_nxt +
                     {coef_r[C_HSWEEP][31], coef_r[C_HSWEEP][31:1]};
      end
    end
    // constant, line, frame and time parts of the phase
    phase_sum = coef_r[C_PHASE] + h_ph_r + v_ph_r +
                t_lin_r + t_sq_r;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hcnt_r <= 12'h000;
      vcnt_r <= 11'h000;
      h_ph_r <= 32'h00000000;
      h_rate_r <= 32'h00000000;
      v_ph_r <= 32'h00000000;
      v_rate_r <= 32'h00000000;
      hxy_r <= 32'h00000000;
      hxt_r <= 32'h00000000;
      vyt_r <= 32'h00000000;
      t_lin_r <= 32'h00000000;
      t_sq_r <= 32'h00000000;
      t_rate_r <= 32'h00000000;
      frames_r <= 16'h0000;
    end else begin
      hcnt_r <= hcnt_nxt;
      vcnt_r <= vcnt_nxt;
      h_ph_r <= h_ph_nxt;
      h_rate_r <= h_rate_nxt;
      v_ph_r <= v_ph_nxt;
      v_rate_r <= v_rate_nxt;
      hxy_r <= hxy_nxt;
      hxt_r <= hxt_nxt;
      vyt_r <= vyt_nxt;
      t_lin_r <= t_lin_nxt;
      t_sq_r <= t_sq_nxt;
      t_rate_r <= t_rate_nxt;
      frames_r <= frames_nxt;
    end
  end

  // ---------------- sine, amplitude and output pipeline ----------------
  logic signed [12:0] sine_s;
  logic signed [12:0] swing_s;

  zpg_sine u_sine (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .phase(phase_sum[31:20]),
    .sine(sine_s)
  );

  zpg_scale u_scale (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sine(sine_s),
    .ampl(ampl_r),
    .swing(swing_s)
  );

  logic [PIPE_DEPTH-1:0] act_d_r, act_d_nxt;
  logic [PIPE_DEPTH-1:0] hs_d_r, hs_d_nxt;
  logic [PIPE_DEPTH-1:0] vs_d_r, vs_d_nxt;
  logic [11:0] c0_r, c0_nxt;
  logic [11:0] c1_r, c1_nxt;
  logic [11:0] c2_r, c2_nxt;
  logic ycc;
  logic [11:0] sub_mid;
  logic [11:0] sub_idle;

  // sync flags ride alongside the sine latency
  always_comb begin
    act_d_nxt = {act_d_r[PIPE_DEPTH-2:0], active_now & run_r};
    hs_d_nxt = {hs_d_r[PIPE_DEPTH-2:0], hcnt_r >= 12'(H_TOTAL - H_SYNC_LEN)};
    vs_d_nxt = {vs_d_r[PIPE_DEPTH-2:0], vcnt_r >= 11'(V_TOTAL - V_SYNC_LEN)};
    ycc = (space_r == SPACE_YCC);
    sub_mid = ycc ? CHROMA_MID : LUMA_MID;
    sub_idle = ycc ? CHROMA_MID : BLACK_CODE;
    // blanking carries idle codes, never the pattern
    if (act_d_r[PIPE_DEPTH-2]) begin
      c0_nxt = chan(enable_r[0], swing_s, LUMA_MID, BLACK_CODE);
      c1_nxt = chan(enable_r[1], swing_s, sub_mid, sub_idle);
      c2_nxt = chan(enable_r[2], swing_s, sub_mid, sub_idle);
    end else begin
      c0_nxt = BLACK_CODE;
      c1_nxt = sub_idle;
      c2_nxt = sub_idle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      act_d_r <= '0;
      hs_d_r <= '0;
      vs_d_r <= '0;
      c0_r <= BLACK_CODE;
      c1_r <= CHROMA_MID;
      c2_r <= CHROMA_MID;
    end else begin
      act_d_r <= act_d_nxt;
      hs_d_r <= hs_d_nxt;
      vs_d_r <= vs_d_nxt;
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign vid_comp0 = c0_r;
  assign vid_comp1 = c1_r;
  assign vid_comp2 = c2_r;
  assign vid_active = act_d_r[PIPE_DEPTH-1];
  assign vid_hsync = hs_d_r[PIPE_DEPTH-1];
  assign vid_vsync = vs_d_r[PIPE_DEPTH-1];
endmodule // zpg_generator

// ===== zpg_generator_sva.sv
// zpg_generator_sva: port checks for the zone plate generator
`timescale 1ns/1ps
module zpg_generator_sva import zpg_pkg::*; (
  input wire logic ref_clk, // sample clock
  input wire logic reset_n, // sync reset, active low
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic avs_waitrequest, // slave stall
  input wire logic [11:0] vid_comp0, // first component
  input wire logic vid_active, // active picture
  input wire logic vid_hsync, // line sync
  input wire logic vid_vsync // frame sync
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int hi_cnt_r;
  int ln_cnt_r;
  int act_cnt_r;
  logic hs_q_r;
  logic seen_r;
  // run lengths; the first line is partial, so wait for one sync rise
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hi_cnt_r <= 0;
      ln_cnt_r <= 0;
      act_cnt_r <= 0;
      hs_q_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      hi_cnt_r <= vid_hsync ? hi_cnt_r + 1 : 0;
      act_cnt_r <= vid_active ? act_cnt_r + 1 : 0;
      ln_cnt_r <= (vid_hsync && !hs_q_r) ? 1 : ln_cnt_r + 1;
      seen_r <= seen_r | (vid_hsync && !hs_q_r);
      hs_q_r <= vid_hsync;
    end
  end
  wait_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without a request");
  hsync_len_a: assert property ($fell(vid_hsync) |-> hi_cnt_r == H_SYNC_LEN)
    else $error("line sync pulse length wrong");
  line_len_a: assert property (vid_hsync && !hs_q_r && seen_r |-> ln_cnt_r == H_TOTAL)
    else $error("line length wrong");
  active_len_a: assert property ($fell(vid_active) |-> act_cnt_r == H_ACTIVE)
    else $error("active span length wrong");
  sync_gap_a: assert property ($fell(vid_active) |-> ##236 $rose(vid_hsync))
    else $error("sync not 236 samples after active end");
  active_sync_a: assert property (vid_active |-> !vid_hsync && !vid_vsync)
    else $error("sync inside active picture");
  swing_range_a: assert property (vid_active |-> vid_comp0 inside {[12'h00D:12'hFA2]})
    else $error("luma beyond maximum swing");
  cover property ($rose(avs_read));
  cover property ($fell(avs_waitrequest) && avs_write);
  cover property ($rose(vid_active));
endmodule // zpg_generator_sva

bind zpg_generator zpg_generator_sva i_zpg_generator_sva (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .vid_comp0(vid_comp0),
  .vid_active(vid_active),
  .vid_hsync(vid_hsync),
  .vid_vsync(vid_vsync)
);

// ===== zpg_wave_monitor.sv
// zpg_wave_monitor: monitor catching a few samples of each active line
`timescale 1ns/1ps
module zpg_wave_monitor (
  input wire logic ref_clk, // sample clock
  input wire logic reset_n, // sync reset, active low
  input wire logic vid_active, // active picture
  input wire logic [11:0] vid_comp0, // first component
  input wire logic [11:0] vid_comp1, // second component
  input wire logic [11:0] vid_comp2, // third component
  output logic [3:0][11:0] cap0_r, // first component, samples 100..103
  output logic [11:0] cap1_r, // second component at sample 100
  output logic [11:0] cap2_r, // third component at sample 100
  output logic [15:0] lines_r // completed active lines
);
  logic [11:0] pos_r;
  // samples well inside the line, clear of any start-of-line effect
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pos_r <= 12'h000;
      lines_r <= 16'h0000;
    end else begin
      pos_r <= vid_active ? pos_r + 12'h001 : 12'h000;
      if (vid_active && pos_r >= 12'h064 && pos_r < 12'h068) begin
        cap0_r[pos_r[1:0]] <= vid_comp0;
      end
      if (vid_active && pos_r == 12'h064) begin
        cap1_r <= vid_comp1;
        cap2_r <= vid_comp2;
      end
      if (!vid_active && pos_r != 12'h000) begin
        lines_r <= lines_r + 16'h0001;
      end
    end
  end
endmodule // zpg_wave_monitor

// ===== zpg_generator_tb.sv
// zpg_generator_tb: register-driven checks of the zone plate generator
`timescale 1ns/1ps
module zpg_generator_tb import zpg_pkg::*; ;
  logic ref_clk;
  logic reset_n;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [11:0] vid_comp0;
  logic [11:0] vid_comp1;
  logic [11:0] vid_comp2;
  logic vid_active;
  logic vid_hsync;
  logic vid_vsync;
  logic [3:0][11:0] cap0;
  logic [11:0] cap1;
  logic [11:0] cap2;
  logic [15:0] lines;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  zpg_generator i_zpg_generator (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .vid_comp0(vid_comp0),
    .vid_comp1(vid_comp1), .vid_comp2(vid_comp2),
    .vid_active(vid_active), .vid_hsync(vid_hsync),
    .vid_vsync(vid_vsync));
  zpg_wave_monitor i_zpg_wave_monitor (.ref_clk(ref_clk),
    .reset_n(reset_n), .vid_active(vid_active), .vid_comp0(vid_comp0),
    .vid_comp1(vid_comp1), .vid_comp2(vid_comp2), .cap0_r(cap0),
    .cap1_r(cap1), .cap2_r(cap2), .lines_r(lines));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hung handshake or raster ends the run here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen,
               exp);
    end
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    check(avs_readdata, exp, what);
    avs_read <= 1'b0;
  endtask

  // two line ends pass, the second closing a whole line, so the new setting fills the captured line
  task automatic wait_lines(input int n);
    logic [15:0] start;
    start = lines;
    while (16'(lines - start) < 16'(n)) @(posedge ref_clk);
  endtask

  task automatic show(input logic [11:0] e0, input logic [11:0] e1,
                      input logic [11:0] e2);
    wait_lines(2);
    check(32'(cap0[0]), 32'(e0), "comp0");
    check(32'(cap1), 32'(e1), "comp1");
    check(32'(cap2), 32'(e2), "comp2");
  endtask

  initial begin
    reset_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(OFS_AMPL, 32'h0000_0578, "ampl reset");
    rd_chk(OFS_ENABLE, 32'h0000_0001, "enable reset");
    rd_chk(8'h40, 32'h0000_0000, "unmapped");
    show(12'h7D8, 12'h800, 12'h800);
    bus_write(OFS_COEF, 32'h4000_0000, 4'hF);
    show(12'hEAD, 12'h800, 12'h800);
    rd_chk(OFS_COEF, 32'h4000_0000, "phase coef");
    rd_chk(8'h50, 32'h0000_0000, "coef alias");
    bus_write(OFS_COEF, 32'hC000_0000, 4'hF);
    show(12'h102, 12'h800, 12'h800);
    bus_write(OFS_AMPL, 32'h0000_0000, 4'hF);
    show(12'h7D8, 12'h800, 12'h800);
    bus_write(OFS_AMPL, 32'h0000_FFFF, 4'hF);
    rd_chk(OFS_AMPL, 32'h0000_063C, "ampl clamp");
    bus_write(OFS_COEF, 32'h4000_0000, 4'hF);
    show(12'hFA2, 12'h800, 12'h800);
    bus_write(OFS_ENABLE, 32'h0000_0006, 4'hF);
    show(12'h100, 12'hFCA, 12'hFCA);
    bus_write(OFS_AMPL, 32'h0000_0000, 4'h2);
    rd_chk(OFS_AMPL, 32'h0000_003C, "ampl lane");
    bus_write(OFS_CTRL, 32'h0000_0007, 4'hF);
    rd_chk(OFS_ENABLE, 32'h0000_0007, "rgb enables");
    rd_chk(OFS_AMPL, 32'h0000_0578, "ampl defaults");
    show(12'hEAD, 12'hEAD, 12'hEAD);
    bus_write(OFS_COEF, 32'h0000_0000, 4'hF);
    bus_write(OFS_COEF + 8'h04, 32'h4000_0000, 4'hF);
    wait_lines(2);
    check(32'(cap0[0]), 32'h0000_07D8, "quarter step 0");
    check(32'(cap0[1]), 32'h0000_0EAD, "quarter step 1");
    check(32'(cap0[2]), 32'h0000_07D8, "quarter step 2");
    check(32'(cap0[3]), 32'h0000_0102, "quarter step 3");
    bus_write(OFS_COEF + 8'h04, 32'h8000_0000, 4'hF);
    show(12'h7D8, 12'h7D8, 12'h7D8);
    stop_test();
  end
endmodule // zpg_generator_tb
